// >>> common/bscan_pkg.sv
// Purpose: constants and types for the boundary scan data path
// Assumes: one 100 MHz clock samples every test port pin
// Notes: Operation list below, one line per behaviour
//
// Operation
// R1: bypass, chain, ident registers share serial path
// R2: chain selected for external test or sample
// R3: external test drives held latches onto pins
// R4: controller preloads cells before external test
// R5: every cell has a falling-edge latch stage
// R6: input cells only sample, never drive
// R7: enable cells built like output cells
// R8: bidirectional pin uses enable plus capture cell
// R9: capture core data when enabled, not external
// R10: capture pad data when disabled or external
// R11: observe inputs, control outputs, both bidirectional
// R12: outside external test, core values pass through
// R13: sample mode/input on rise, output on fall
// R14: serial output driven only while shifting
// R15: opcodes 000000 external test, 000001 sample
// R16: bypass bit loads zero at data capture
package bscan_pkg;

  // instruction register
  localparam int        IR_W        = 6;
  localparam logic [5:0] OP_EXTEST  = 6'h00;
  localparam logic [5:0] OP_SAMPLE  = 6'h01;
  localparam logic [5:0] OP_IDCODE  = 6'h02;
  localparam logic [5:0] IR_CAPTURE = 6'h2d;  // low bits 01 by standard
  localparam logic [5:0] IR_RESET   = OP_IDCODE;

  // pin counts of the scanned ring
  localparam int N_IN   = 4;
  localparam int N_OUT  = 4;
  localparam int N_BIDI = 2;
  localparam int CHAIN_W = N_IN + N_OUT + 2 * N_BIDI;
  localparam int OUT_BASE  = N_IN;
  localparam int BIDI_BASE = N_IN + N_OUT;

  // identification word, value arbitrary, lsb fixed at one
  localparam logic [31:0] IDCODE_VAL = 32'h0000_0001;
  localparam logic        BYPASS_CAP = 1'h0;

  // test port pins as one group
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } tap_pins_type;

  // sixteen controller states
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_type;

endpackage : bscan_pkg

// >>> logic/bscan_cell.sv
// Purpose: one boundary cell: capture/shift stage, falling latch, update
// Assumes: enables are one-cycle pulses on the reference clock
// Notes: HAS_UPD=0 builds a sample-only cell with no drive path
`timescale 1ns/1ns
module bscan_cell #(
  parameter bit HAS_UPD = 1'b1
) (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // test clock phase enables
  input  wire logic i_cap_en,
  input  wire logic i_shift_en,
  input  wire logic i_fall_en,
  input  wire logic i_upd_en,
  // data
  input  wire logic i_par,
  input  wire logic i_ser,
  output logic      o_ser,
  output logic      o_upd
);
  logic shift_ff;  // capture and shift stage, moves on test clock rise
  logic neg_ff;    // falling-edge copy, keeps skew away from the update

  // capture or shift on rising test clock
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) shift_ff <= 1'b0;
    else if (i_cap_en) shift_ff <= i_par;
    else if (i_shift_en) shift_ff <= i_ser;
  end

  // falling-edge latch stage
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) neg_ff <= 1'b0;
    else if (i_fall_en) neg_ff <= shift_ff;  // R5
  end

  assign o_ser = shift_ff;

  generate
    if (HAS_UPD) begin : g_upd
      logic upd_ff;  // held value for driving during external test
      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) upd_ff <= 1'b0;
        else if (i_upd_en) upd_ff <= neg_ff;
      end
      assign o_upd = upd_ff;
    end else begin : g_obs
      // sample-only cell drives nothing
      assign o_upd = 1'b0;  // R6
    end
  endgenerate
endmodule : bscan_cell

// >>> logic/bscan_path.sv
// Purpose: test port controller and data registers with boundary ring
// Assumes: test clock is far slower than the reference clock
// Notes: pin outputs lag their cause by one reference clock
`timescale 1ns/1ns
module bscan_path (
  // clock and reset
  input  wire logic                           i_ref_clk,
  input  wire logic                           i_rst,
  // test port pins
  input  wire bscan_pkg::tap_pins_type        i_tap,
  output logic                                o_tdo,
  output logic                                o_tdo_oe,
  // input-only pins
  input  wire logic [bscan_pkg::N_IN-1:0]     i_pin_in,
  // output pins
  input  wire logic [bscan_pkg::N_OUT-1:0]    i_core_out,
  output logic      [bscan_pkg::N_OUT-1:0]    o_pin_out,
  // bidirectional pins
  input  wire logic [bscan_pkg::N_BIDI-1:0]   i_core_bd,
  input  wire logic [bscan_pkg::N_BIDI-1:0]   i_core_bd_oe,
  input  wire logic [bscan_pkg::N_BIDI-1:0]   i_pad_bd,
  output logic      [bscan_pkg::N_BIDI-1:0]   o_pad_bd,
  output logic      [bscan_pkg::N_BIDI-1:0]   o_pad_bd_oe
);
  localparam int NI = bscan_pkg::N_IN;
  localparam int NO = bscan_pkg::N_OUT;
  localparam int NB = bscan_pkg::N_BIDI;
  localparam int CW = bscan_pkg::CHAIN_W;

  // two-stage synchronisers for all pins
  bscan_pkg::tap_pins_type tap_s1_ff, tap_s2_ff;
  logic                    tck_d_ff;     // previous synced test clock
  logic [NI-1:0]           in_s1_ff, in_s2_ff;
  logic [NB-1:0]           bd_s1_ff, bd_s2_ff;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tap_s1_ff <= '0;
      tap_s2_ff <= '0;
      tck_d_ff  <= 1'b0;
      in_s1_ff  <= '0;
      in_s2_ff  <= '0;
      bd_s1_ff  <= '0;
      bd_s2_ff  <= '0;
    end else begin
      tap_s1_ff <= i_tap;
      tap_s2_ff <= tap_s1_ff;
      tck_d_ff  <= tap_s2_ff.tck;
      in_s1_ff  <= i_pin_in;
      in_s2_ff  <= in_s1_ff;
      bd_s1_ff  <= i_pad_bd;
      bd_s2_ff  <= bd_s1_ff;
    end
  end

  // test clock edges as one-cycle enables
  wire tck_rise = tap_s2_ff.tck & ~tck_d_ff;
  wire tck_fall = ~tap_s2_ff.tck & tck_d_ff;

  // controller state
  bscan_pkg::tap_state_type state_ff, nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      bscan_pkg::TLR:    nxt_state = tap_s2_ff.tms ? bscan_pkg::TLR
                                                   : bscan_pkg::RTI;
      bscan_pkg::RTI:    nxt_state = tap_s2_ff.tms ? bscan_pkg::SEL_DR
                                                   : bscan_pkg::RTI;
      bscan_pkg::SEL_DR: nxt_state = tap_s2_ff.tms ? bscan_pkg::SEL_IR
                                                   : bscan_pkg::CAP_DR;
      bscan_pkg::CAP_DR: nxt_state = tap_s2_ff.tms ? bscan_pkg::EX1_DR
                                                   : bscan_pkg::SH_DR;
      bscan_pkg::SH_DR:  nxt_state = tap_s2_ff.tms ? bscan_pkg::EX1_DR
                                                   : bscan_pkg::SH_DR;
      bscan_pkg::EX1_DR: nxt_state = tap_s2_ff.tms ? bscan_pkg::UPD_DR
                                                   : bscan_pkg::PA_DR;
      bscan_pkg::PA_DR:  nxt_state = tap_s2_ff.tms ? bscan_pkg::EX2_DR
                                                   : bscan_pkg::PA_DR;
      bscan_pkg::EX2_DR: nxt_state = tap_s2_ff.tms ? bscan_pkg::UPD_DR
                                                   : bscan_pkg::SH_DR;
      bscan_pkg::UPD_DR: nxt_state = tap_s2_ff.tms ? bscan_pkg::SEL_DR
                                                   : bscan_pkg::RTI;
      bscan_pkg::SEL_IR: nxt_state = tap_s2_ff.tms ? bscan_pkg::TLR
                                                   : bscan_pkg::CAP_IR;
      bscan_pkg::CAP_IR: nxt_state = tap_s2_ff.tms ? bscan_pkg::EX1_IR
                                                   : bscan_pkg::SH_IR;
      bscan_pkg::SH_IR:  nxt_state = tap_s2_ff.tms ? bscan_pkg::EX1_IR
                                                   : bscan_pkg::SH_IR;
      bscan_pkg::EX1_IR: nxt_state = tap_s2_ff.tms ? bscan_pkg::UPD_IR
                                                   : bscan_pkg::PA_IR;
      bscan_pkg::PA_IR:  nxt_state = tap_s2_ff.tms ? bscan_pkg::EX2_IR
                                                   : bscan_pkg::PA_IR;
      bscan_pkg::EX2_IR: nxt_state = tap_s2_ff.tms ? bscan_pkg::UPD_IR
                                                   : bscan_pkg::SH_IR;
      bscan_pkg::UPD_IR: nxt_state = tap_s2_ff.tms ? bscan_pkg::SEL_DR
                                                   : bscan_pkg::RTI;
      default:           nxt_state = bscan_pkg::TLR;
    endcase
  end

  // state moves on the sampled rise, test reset pin forces reset state
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) state_ff <= bscan_pkg::TLR;
    else if (!tap_s2_ff.trst_n) state_ff <= bscan_pkg::TLR;
    else if (tck_rise) state_ff <= nxt_state;  // R13
  end

  // state decodes, all but in_tlr and shifting gated by the rise
  wire in_tlr  = (state_ff == bscan_pkg::TLR);
  wire cap_dr  = tck_rise & (state_ff == bscan_pkg::CAP_DR);
  wire sh_dr   = tck_rise & (state_ff == bscan_pkg::SH_DR);
  wire upd_dr  = tck_rise & (state_ff == bscan_pkg::UPD_DR);
  wire cap_ir  = tck_rise & (state_ff == bscan_pkg::CAP_IR);
  wire sh_ir   = tck_rise & (state_ff == bscan_pkg::SH_IR);
  wire upd_ir  = tck_rise & (state_ff == bscan_pkg::UPD_IR);
  wire shifting = (state_ff == bscan_pkg::SH_DR) |
                  (state_ff == bscan_pkg::SH_IR);

  // instruction shift stage and current instruction
  logic [5:0] ir_sh_ff;  // shifted in, not yet in force
  logic [5:0] ir_ff;     // current instruction

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ir_sh_ff <= bscan_pkg::IR_RESET;
      ir_ff    <= bscan_pkg::IR_RESET;
    end else if (in_tlr) begin
      ir_sh_ff <= bscan_pkg::IR_RESET;
      ir_ff    <= bscan_pkg::IR_RESET;
    end else begin
      if (cap_ir) ir_sh_ff <= bscan_pkg::IR_CAPTURE;
      else if (sh_ir) ir_sh_ff <= {tap_s2_ff.tdi, ir_sh_ff[5:1]};
      if (upd_ir) ir_ff <= ir_sh_ff;
    end
  end

  // instruction decode; anything unlisted selects bypass
  wire op_extest = (ir_ff == bscan_pkg::OP_EXTEST);  // R15
  wire op_sample = (ir_ff == bscan_pkg::OP_SAMPLE);  // R15
  wire op_ident  = (ir_ff == bscan_pkg::OP_IDCODE);
  wire sel_chain = op_extest | op_sample;            // R2

  // bypass and identification registers
  logic        bypass_ff;
  logic [31:0] id_ff;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      bypass_ff <= 1'b0;
      id_ff     <= bscan_pkg::IDCODE_VAL;
    end else begin
      if (cap_dr) bypass_ff <= bscan_pkg::BYPASS_CAP;  // R16
      else if (sh_dr) bypass_ff <= tap_s2_ff.tdi;
      if (cap_dr) id_ff <= bscan_pkg::IDCODE_VAL;
      else if (sh_dr && op_ident) id_ff <= {tap_s2_ff.tdi, id_ff[31:1]};
    end
  end

  // boundary ring: capture values, serial links and update outputs
  logic [CW-1:0] cell_par;
  logic [CW-1:0] cell_ser;
  logic [CW-1:0] cell_upd;
  wire  [CW:0]   chain_in = {tap_s2_ff.tdi, cell_ser};  // tdi enters top

  // capture choice of each bidirectional capture cell
  wire [NB-1:0] bd_cap_val;

  genvar g;
  generate
    for (g = 0; g < CW; g++) begin : g_cell
      localparam bit DRV = (g >= bscan_pkg::OUT_BASE);  // R11
      bscan_cell #(.HAS_UPD(DRV)) u_cell (
        .i_ref_clk  (i_ref_clk),
        .i_rst      (i_rst),
        .i_cap_en   (cap_dr & sel_chain),
        .i_shift_en (sh_dr & sel_chain),
        .i_fall_en  (tck_fall),
        .i_upd_en   (upd_dr & sel_chain),
        .i_par      (cell_par[g]),
        .i_ser      (chain_in[g+1]),
        .o_ser      (cell_ser[g]),
        .o_upd      (cell_upd[g])
      );
    end
    for (g = 0; g < NI; g++) begin : g_in
      assign cell_par[g] = in_s2_ff[g];  // R6
    end
    for (g = 0; g < NO; g++) begin : g_out
      assign cell_par[bscan_pkg::OUT_BASE+g] = i_core_out[g];
    end
    for (g = 0; g < NB; g++) begin : g_bd
      // enable cell is an output-style cell, capture cell picks source
      assign bd_cap_val[g] = (i_core_bd_oe[g] & ~op_extest)   // R9 R10
                             ? i_core_bd[g] : bd_s2_ff[g];
      assign cell_par[bscan_pkg::BIDI_BASE+2*g]   = i_core_bd_oe[g];  // R7
      assign cell_par[bscan_pkg::BIDI_BASE+2*g+1] = bd_cap_val[g];    // R8
    end
  endgenerate

  // serial output source: only the selected register reaches tdo
  wire dr_ser  = sel_chain ? cell_ser[0] :            // R1
                 op_ident  ? id_ff[0] : bypass_ff;
  wire tdo_src = (state_ff == bscan_pkg::SH_IR) ? ir_sh_ff[0] : dr_ser;

  // serial output changes only on the falling test clock
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tdo    <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      o_tdo    <= tdo_src;   // R13
      o_tdo_oe <= shifting;  // R14
    end
  end

  // held values go to pins as soon as external test is in force
  wire [NO-1:0] out_upd = cell_upd[bscan_pkg::OUT_BASE +: NO];
  logic [NB-1:0] bd_upd_oe, bd_upd_d;
  always_comb begin
    for (int i = 0; i < NB; i++) begin
      bd_upd_oe[i] = cell_upd[bscan_pkg::BIDI_BASE+2*i];
      bd_upd_d[i]  = cell_upd[bscan_pkg::BIDI_BASE+2*i+1];
    end
  end

  // pin drive register; one clock of latency keeps outputs glitch free
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_out   <= '0;
      o_pad_bd    <= '0;
      o_pad_bd_oe <= '0;
    end else if (op_extest) begin
      o_pin_out   <= out_upd;    // R3
      o_pad_bd    <= bd_upd_d;   // R3
      o_pad_bd_oe <= bd_upd_oe;  // R7
    end else begin
      o_pin_out   <= i_core_out;    // R12
      o_pad_bd    <= i_core_bd;     // R12
      o_pad_bd_oe <= i_core_bd_oe;  // R12
    end
  end

  // checks
  sequence s_fall_not_shift;
    tck_fall && !shifting;
  endsequence

  bypass_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R16
    cap_dr |=> !bypass_ff) else $error("bypass not zero after capture");
  tdo_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R14
    s_fall_not_shift |=> !o_tdo_oe) else $error("tdo driven while idle");
  tdo_fall_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R13
    $changed(o_tdo) |-> $past(tck_fall)) else $error("tdo moved off fall");
  chain_sel_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R2
    (tck_fall && sel_chain && state_ff == bscan_pkg::SH_DR)
      |=> o_tdo == $past(cell_ser[0])) else $error("chain not on tdo");
  extest_drive_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R3
    op_extest |=> o_pin_out == $past(out_upd) && o_pad_bd_oe ==
      $past(bd_upd_oe)) else $error("held values not on pins");
  normal_pass_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R12
    !op_extest |=> o_pin_out == $past(i_core_out))
    else $error("core output not passed");
  bidi_capture_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R9
    (cap_dr && sel_chain) |=> cell_ser[bscan_pkg::BIDI_BASE+1] ==
      $past(i_core_bd_oe[0] && !op_extest ? i_core_bd[0] : bd_s2_ff[0]))
    else $error("bidirectional capture wrong source");
  ir_update_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R15
    (upd_ir && tap_s2_ff.trst_n) |=> ir_ff == $past(ir_sh_ff))
    else $error("instruction not taken at update");
endmodule : bscan_path

// >>> test/tap_ctrl_model.sv
// Purpose: external test controller driving the four-wire test port
// Assumes: one link clock of 160 ns, both halves timed on ref edges
// Notes: link clock stands low between scans; tdo is sampled before rise
`timescale 1ns/1ns
module tap_ctrl_model (
  // reference clock, only for timing the link clock
  input  wire logic               i_ref_clk,
  // test port toward the device
  output bscan_pkg::tap_pins_type o_tap,
  input  wire logic               i_tdo,
  input  wire logic               i_tdo_oe
);
  logic hold_ok;  // tdo never moved while the link clock was high

  // idle port: test reset held low until the bench releases it
  initial begin
    o_tap.tck    = 1'b0;
    o_tap.tms    = 1'b1;
    o_tap.tdi    = 1'b1;
    o_tap.trst_n = 1'b0;
    hold_ok      = 1'b1;
  end

  // half a link period, landing just after a ref edge
  task automatic half();
    repeat (8) @(posedge i_ref_clk);
    #1;
  endtask : half

  // one link clock: mode and data settle while low, taken at the rise
  task automatic pulse(input logic tms, input logic tdi,
                       output logic tdo, output logic oe);
    o_tap.tms = tms;
    o_tap.tdi = tdi;
    half();
    tdo = i_tdo;
    oe  = i_tdo_oe;
    o_tap.tck = 1'b1;
    half();
    if (i_tdo !== tdo) hold_ok = 1'b0;
    o_tap.tck = 1'b0;
  endtask : pulse

  // test reset pulse, then five ones and a zero into idle
  task automatic reset_tap();
    logic t, e;
    o_tap.trst_n = 1'b0;
    half();
    o_tap.trst_n = 1'b1;
    half();
    repeat (5) pulse(1'b1, 1'b1, t, e);
    pulse(1'b0, 1'b1, t, e);
  endtask : reset_tap

  // full scan from idle back to idle; ir picks the instruction path
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic oe_all);
    logic t, e;
    dout   = 32'h0;
    oe_all = 1'b1;
    pulse(1'b1, 1'b0, t, e);
    if (ir) pulse(1'b1, 1'b0, t, e);
    pulse(1'b0, 1'b0, t, e);
    pulse(1'b0, 1'b0, t, e);
    // last shift bit leaves the shift state with mode high
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], t, e);
      dout[i] = t;
      oe_all &= e;
    end
    pulse(1'b1, 1'b0, t, e);
    pulse(1'b0, 1'b0, t, e);
  endtask : scan
endmodule : tap_ctrl_model

// >>> test/testbench.sv
// Purpose: self-checking bench for the boundary scan data path
// Assumes: controller model owns the test port, bench owns the pins
// Notes: pad levels are resolved here from the device's enable alone
`timescale 1ns/1ns
module testbench;
  localparam logic [11:0] PRE = 12'h695;  // preload, bidi0 released
  localparam logic [11:0] NXT = 12'h5c3;  // second pattern, both driving
  logic                    i_ref_clk;
  logic                    i_rst;
  bscan_pkg::tap_pins_type tap;
  logic                    o_tdo, o_tdo_oe, tdo_line, tdo_last;
  logic [3:0]              pin_in, core_out, pin_out;
  logic [1:0]              core_bd, core_bd_oe, pad_bd;
  logic [1:0]              pad_out, pad_oe, ext_bd;
  int                      n_errors, compares;
  logic [31:0]             dout;
  logic                    oe_all;

  // released tdo shows the inverse of its last level, not a stale copy
  always @(posedge i_ref_clk) if (o_tdo_oe) tdo_last <= o_tdo;
  assign tdo_line = o_tdo_oe ? o_tdo : ~tdo_last;
  // pad level: device when enabled, else the board's own driver
  assign pad_bd = (pad_oe & pad_out) | (~pad_oe & ext_bd);

  bscan_path uut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_tap(tap),
    .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_pin_in(pin_in),
    .i_core_out(core_out), .o_pin_out(pin_out), .i_core_bd(core_bd),
    .i_core_bd_oe(core_bd_oe), .i_pad_bd(pad_bd), .o_pad_bd(pad_out),
    .o_pad_bd_oe(pad_oe));
  tap_ctrl_model ctrl (
    .i_ref_clk(i_ref_clk), .o_tap(tap), .i_tdo(tdo_line),
    .i_tdo_oe(o_tdo_oe));

  // compare and count
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // verdict and stop
  task automatic end_sim();
    if (n_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // pins follow the core outside external test
  task automatic pins_core();
    check("pin_out", {28'h0, pin_out}, {28'h0, core_out});
    check("pad_out", {30'h0, pad_out}, {30'h0, core_bd});
    check("pad_oe", {30'h0, pad_oe}, {30'h0, core_bd_oe});
  endtask : pins_core

  // reset leaves identification selected; tdo driven only in shift
  task automatic t_ident();
    ctrl.scan(1'b0, 32, 32'h0, dout, oe_all);
    check("ident", dout, bscan_pkg::IDCODE_VAL);
    check("oe_shift", {31'h0, oe_all}, 32'h1);
    check("oe_idle", {31'h0, o_tdo_oe}, 32'h0);
    pins_core();
  endtask : t_ident

  // bypass is one bit long and captures zero
  task automatic t_bypass();
    ctrl.scan(1'b1, 6, 32'h3f, dout, oe_all);
    ctrl.scan(1'b0, 3, 32'h3, dout, oe_all);
    check("bypass", {29'h0, dout[2:0]}, 32'h6);
  endtask : t_bypass

  // sample captures pins and bidi mux, then preloads the latches
  task automatic t_sample();
    logic [11:0] exp;
    exp = {ext_bd[1], core_bd_oe[1], core_bd[0], core_bd_oe[0],
           core_out, pin_in};
    ctrl.scan(1'b1, 6, {26'h0, bscan_pkg::OP_SAMPLE}, dout, oe_all);
    ctrl.scan(1'b0, 12, {20'h0, PRE}, dout, oe_all);
    check("sample_cap", {20'h0, dout[11:0]}, {20'h0, exp});
    pins_core();
  endtask : t_sample

  // external test drives the preload, pad wins the capture mux
  task automatic t_extest();
    logic [11:0] exp;
    ctrl.scan(1'b1, 6, {26'h0, bscan_pkg::OP_EXTEST}, dout, oe_all);
    check("ext_out", {28'h0, pin_out}, {28'h0, PRE[7:4]});
    check("ext_oe", {30'h0, pad_oe}, {30'h0, PRE[10], PRE[8]});
    check("ext_pad", {30'h0, pad_out}, {30'h0, PRE[11], PRE[9]});
    pin_in = 4'h3;
    exp = {PRE[11], 1'b0, ext_bd[0], 1'b0, 4'h0, pin_in};
    ctrl.scan(1'b0, 12, {20'h0, NXT}, dout, oe_all);
    check("ext_cap", {20'h0, dout[11:0] & 12'ha0f}, {20'h0, exp});
    check("upd_out", {28'h0, pin_out}, {28'h0, NXT[7:4]});
    check("upd_oe", {30'h0, pad_oe}, {30'h0, NXT[10], NXT[8]});
    check("upd_pad", {30'h0, pad_out}, {30'h0, NXT[11], NXT[9]});
    ctrl.scan(1'b1, 6, 32'h3f, dout, oe_all);
    pins_core();
    check("hold", {31'h0, ctrl.hold_ok}, 32'h1);
  endtask : t_extest

  // reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // watchdog: the whole run needs well under 40 us
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end

  // main sequence
  initial begin
    i_rst      = 1'b1;
    pin_in     = 4'ha;
    core_out   = 4'h6;
    core_bd    = 2'h1;
    core_bd_oe = 2'h1;
    ext_bd     = 2'h2;
    tdo_last   = 1'b0;
    n_errors   = 0;
    compares   = 0;
    repeat (12) @(posedge i_ref_clk);
    #1;
    i_rst = 1'b0;
    ctrl.reset_tap();
    t_ident();
    t_bypass();
    t_sample();
    t_extest();
    end_sim();
  end
endmodule : testbench
